// ### bench/iss_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module iss_i2c_master (
  // clock and slave drives
  input  wire logic hclk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // wires and hang flag
  output logic      scl_wire,
  output logic      sda_wire,
  output logic      stuck
);
  logic m_scl;
  logic m_sda;
  // pull-ups: released lines float high
  assign scl_wire = !(m_scl || scl_oe);
  assign sda_wire = !(m_sda || sda_oe);
  initial
  begin
    m_scl = 1'b0;
    m_sda = 1'b0;
    stuck = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic start_c();
    m_sda <= 1'b1;
    wt(4);
    m_scl <= 1'b1;
    wt(4);
  endtask
  task automatic stop_c();
    m_sda <= 1'b1;
    wt(4);
    m_scl <= 1'b0;
    wt(4);
    m_sda <= 1'b0;
    wt(4);
  endtask
  task automatic put_bit(input logic b, input int lo, output logic smp);
    int n;
    m_sda <= !b;
    wt(lo);
    m_scl <= 1'b0;
    n = 0;
    @(negedge hclk);
    while (!scl_wire && n < 5000)
    begin
      @(negedge hclk);
      n++;
    end
    stuck = stuck || (n >= 5000);
    wt(3);
    smp = sda_wire;
    m_scl <= 1'b1;
    wt(1);
  endtask
  // long first low phase leaves room for the slave to stretch
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
      put_bit(tx[i], (i == 7) ? 12 : 4, rx[i]);
  endtask
endmodule
`default_nettype wire

// ### bench/iss_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iss_slave_asserts
  import iss_pkg::*;
(
  // bus side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // i2c side
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  logic rd_req;
  assign rd_req = hsel && htrans[1] && hready && !hwrite && (hsize == SIZE_WORD);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_hold_status: assert property (rd_req && haddr[7:0] == OFS_STATUS
    |=> hrdata[STA_HOLD] == $past(scl_oe)) else $error("status hold bit wrong");
  a_status_spare: assert property (rd_req && haddr[7:0] == OFS_STATUS
    |=> hrdata[31:8] == 24'h00_0000 && hrdata[6:5] == 2'h0) else $error("status spare bits set");
  a_addr_spare: assert property (rd_req && haddr[7:0] == OFS_ADDR
    |=> hrdata[31:24] == 8'h00 && !hrdata[16] && hrdata[14:11] == 4'h0) else $error("address spare bits set");
  a_data_width: assert property (rd_req && haddr[7:0] == OFS_DATA
    |=> hrdata[31:8] == 24'h00_0000) else $error("data upper bits set");
  a_unmapped_zero: assert property (rd_req && haddr[7:0] == 8'h08
    |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_no_wait: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  a_drive_low: assert property (!scl_out && !sda_out)
    else $error("open drain pin drives high");
  a_sda_in_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled while scl high");
  a_hold_in_low: assert property ($rose(scl_oe) |-> !scl_in)
    else $error("stretch begun while scl high");
endmodule
bind iss_slave iss_slave_asserts chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe)
);
`default_nettype wire

// ### bench/iss_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
module iss_slave_test;
  import iss_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        scl_out;
  logic        scl_oe;
  logic        sda_out;
  logic        sda_oe;
  logic        scl_w;
  logic        sda_w;
  logic        stuck;
  logic [31:0] rd;
  logic [7:0]  rx;
  logic        s;
  int          err_total;
  int          checks;
  iss_slave #(.TOUT_CYCLES(200)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe)
  );
  iss_i2c_master mst_u (
    .hclk(hclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_wire(scl_w), .sda_wire(sda_w), .stuck(stuck)
  );
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic edge_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_total++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  // low two status bits: clash and bus error
  task automatic stchk(input logic [31:0] e);
    ahb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0003, e);
  endtask
  // slave stretch seen within a bounded wait
  task automatic wait_hold(input logic e);
    int n;
    n = 0;
    @(negedge hclk);
    while (scl_oe !== 1'b1 && n < 30)
    begin
      @(negedge hclk);
      n++;
    end
    chk(32'(scl_oe), 32'(e));
    @(posedge hclk);
  endtask
  initial
  begin
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0000_0000;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = SIZE_WORD;
    hwdata    = 32'h0000_0000;
    err_total = 0;
    checks    = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(OFS_ADDR, ADDR_RST);
    rchk(OFS_DATA, 32'(DATA_RST));
    ahb(1'b1, OFS_ADDR, 32'h0002_0055);
    rchk(OFS_ADDR, 32'h0002_0055);
    ahb(1'b1, OFS_CTRL, 32'h0000_0001);
    ahb(1'b1, OFS_ADDR, 32'h0000_0000);
    rchk(OFS_ADDR, 32'h0002_0055);
    rchk(8'h08, 32'h0000_0000);
    mst_u.start_c();
    mst_u.xfer(8'h54, rx);
    wait_hold(1'b1);
    rchk(OFS_FLAGS, 32'h0000_0002);
    rchk(OFS_STATUS, 32'h0000_0080);
    ahb(1'b1, OFS_FLAGS, 32'h0000_0002);
    rchk(OFS_STATUS, 32'h0000_0000);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0000);
    mst_u.xfer(8'hA5, rx);
    wait_hold(1'b1);
    rchk(OFS_DATA, 32'h0000_00A5);
    ahb(1'b1, OFS_CTRL, 32'h0000_0061);
    rchk(OFS_FLAGS, 32'h0000_0000);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0000);
    mst_u.stop_c();
    mst_u.start_c();
    mst_u.xfer(8'h58, rx);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0001);
    mst_u.stop_c();
    mst_u.start_c();
    mst_u.xfer(8'h57, rx);
    wait_hold(1'b1);
    rchk(OFS_STATUS, 32'h0000_0088);
    ahb(1'b1, OFS_CTRL, 32'h0000_0061);
    mst_u.put_bit(1'b1, 12, s);
    wait_hold(1'b1);
    ahb(1'b1, OFS_DATA, 32'h0000_0081);
    mst_u.xfer(8'hFF, rx);
    chk(32'(rx), 32'h0000_0081);
    mst_u.put_bit(1'b1, 12, s);
    rchk(OFS_STATUS, 32'h0000_000C);
    mst_u.stop_c();
    mst_u.start_c();
    mst_u.xfer(8'h55, rx);
    wait_hold(1'b1);
    ahb(1'b1, OFS_FLAGS, 32'h0000_0002);
    mst_u.put_bit(1'b1, 12, s);
    wait_hold(1'b1);
    ahb(1'b1, OFS_DATA, 32'h0000_0081);
    mst_u.xfer(8'h7F, rx);
    mst_u.put_bit(1'b0, 12, s);
    wait_hold(1'b0);
    mst_u.stop_c();
    ahb(1'b1, OFS_STATUS, 32'h0000_0000);
    rchk(OFS_STATUS, 32'h0000_000E);
    chk(rd & 32'h0000_0002, 32'h0000_0002);
    mst_u.start_c();
    mst_u.stop_c();
    stchk(32'h0000_0003);
    ahb(1'b1, OFS_STATUS, 32'h0000_0001);
    stchk(32'h0000_0002);
    mst_u.start_c();
    mst_u.stop_c();
    mst_u.start_c();
    mst_u.xfer(8'h00, rx);
    wait_hold(1'b1);
    ahb(1'b1, OFS_CTRL, 32'h0000_0061);
    stchk(32'h0000_0000);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0000);
    mst_u.stop_c();
    // timeout in frame, then wait command
    ahb(1'b1, OFS_CTRL, 32'h0000_0081);
    mst_u.start_c();
    repeat (250) @(posedge hclk);
    stchk(32'h0000_0001);
    mst_u.stop_c();
    mst_u.start_c();
    mst_u.xfer(8'h54, rx);
    wait_hold(1'b1);
    ahb(1'b1, OFS_CTRL, 32'h0000_0041);
    stchk(32'h0000_0000);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0001);
    mst_u.stop_c();
    // smart data read releases the byte
    ahb(1'b1, OFS_CTRL, 32'h0000_0003);
    mst_u.start_c();
    mst_u.xfer(8'h54, rx);
    wait_hold(1'b1);
    ahb(1'b1, OFS_FLAGS, 32'h0000_0002);
    mst_u.put_bit(1'b1, 12, s);
    mst_u.xfer(8'h3C, rx);
    wait_hold(1'b1);
    rchk(OFS_DATA, 32'h0000_003C);
    // smart read acts two cycles late
    @(posedge hclk);
    rchk(OFS_FLAGS, 32'h0000_0001);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0000);
    mst_u.stop_c();
    ahb(1'b1, OFS_CTRL, 32'h0000_0000);
    ahb(1'b1, OFS_ADDR, 32'h0002_0054);
    ahb(1'b1, OFS_CTRL, 32'h0000_0011);
    mst_u.start_c();
    mst_u.xfer(8'h00, rx);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0001);
    mst_u.stop_c();
    mst_u.start_c();
    mst_u.xfer(8'h10, rx);
    wait_hold(1'b1);
    ahb(1'b1, OFS_CTRL, 32'h0000_0071);
    mst_u.put_bit(1'b1, 12, s);
    chk(32'(s), 32'h0000_0000);
    mst_u.stop_c();
    chk(32'(stuck), 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### hw/iss_pkg.sv
package iss_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ADDR   = 8'h14;
  localparam logic [7:0] OFS_DATA   = 8'h18;
  localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
  // writable bits of slave_address_match, the rest read 0
  localparam logic [31:0] ADDR_WMASK = 32'h00FE_87FF;
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic [2:0]  SIZE_WORD = 3'h2;
  // slave_address_match fields
  localparam int ADR_GC   = 0;
  localparam int ADR_LO   = 1;
  localparam int ADR_TEN  = 15;
  localparam int MSK_LO   = 17;
  // control fields
  localparam int CTL_EN   = 0;
  localparam int CTL_SM   = 1;
  localparam int CTL_NACK = 2;
  localparam int CTL_AM   = 3;
  localparam int CTL_CMD  = 5;
  localparam int CTL_TO   = 7;
  // status fields
  localparam int STA_BERR = 0;
  localparam int STA_CLSH = 1;
  localparam int STA_RXNK = 2;
  localparam int STA_DIR  = 3;
  localparam int STA_SR   = 4;
  localparam int STA_HOLD = 7;
  // event flag fields
  localparam int FLG_STOP  = 0;
  localparam int FLG_MATCH = 1;
  localparam int FLG_DONE  = 2;
  // commands and match schemes
  localparam logic [1:0] CMD_WAIT_START = 2'h2;
  localparam logic [1:0] CMD_RESPOND    = 2'h3;
  localparam logic [1:0] AM_MASK        = 2'h0;
  localparam logic [1:0] AM_TWO         = 2'h1;
  localparam logic [1:0] AM_RANGE       = 2'h2;
  localparam logic [7:0] GENERAL_CALL   = 8'h00;
  localparam logic [4:0] TEN_PREFIX     = 5'h1E;
  // bit counting
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam logic [3:0] BITS_FRAME = 4'h9;
  localparam logic [3:0] FRAME_ONE  = 4'h1;
  localparam logic [3:0] FRAME_MID  = 4'h2;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LOW_TOUT_MS   = 25;
  localparam int unsigned LOW_TOUT_CYC  = LOW_TOUT_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_ADDR  = 8'b0000_0010,
    ST_AHOLD = 8'b0000_0100,
    ST_ACK   = 8'b0000_1000,
    ST_RX    = 8'b0001_0000,
    ST_DHOLD = 8'b0010_0000,
    ST_TX    = 8'b0100_0000,
    ST_MACK  = 8'b1000_0000
  } iss_state_e;

  typedef struct packed {
    logic       tout_en;
    logic [1:0] scheme;
    logic       reply_nack;
    logic       smart;
    logic       enable;
  } iss_ctrl_s;
endpackage

// ### hw/iss_slave.sv
`timescale 1ns/1ps
`default_nettype none
module iss_slave
  import iss_pkg::*;
#(
  parameter int unsigned TOUT_CYCLES = LOW_TOUT_CYC
) (
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // i2c pins, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  logic [1:0]  pins_s;
  logic        scl_s, sda_s, scl_d_ff, sda_d_ff;
  logic        scl_rise, scl_fall, start_det, stop_det;
  iss_ctrl_s   ctrl_ff;
  logic [31:0] addr_ff;
  logic [7:0]  data_ff, shift_ff, nxt_shift;
  logic        match_ff, done_ff, stop_ff;
  logic        berr_ff, clash_ff, received_negative_ack_ff, dir_ff, sr_ff;
  logic        dp_wr_ff;
  logic [7:0]  dp_addr_ff;
  logic [1:0]  sm_pipe_ff;
  iss_state_e  st_ff, nxt_st;
  logic [3:0]  bit_ff, nxt_bit, frame_ff;
  logic        bus_act_ff, ten_first_ff, ten_hit_ff, nxt_ten_first, nxt_ten_hit;
  logic        nxt_scl_oe, nxt_sda_oe;
  logic [21:0] tout_ff;
  logic        rs_ff, fresh_ff;
  logic        ap_ok, rd_now, wr_ctrl, wr_flags, wr_status, wr_addr, wr_data;
  logic        cmd_resp, cmd_wait, match_clr, done_clr, err_clr, sm_trig;
  logic        ev_match, ev_done, ev_rx, ev_clash, ev_stop, ev_mack, ev_berr, tout_hit;
  logic [6:0]  a7, msk, rx7;
  logic        m7, gc, ten_hi;

  iss_sync #(.WIDTH(2)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   ({scl_in, sda_in}),
    .dout  (pins_s)
  );
  assign scl_s     = pins_s[1];
  assign sda_s     = pins_s[0];
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // bus decode: zero wait states, low byte of haddr decoded
  assign ap_ok     = hsel & htrans[1] & hready & (hsize == SIZE_WORD);
  assign rd_now    = ap_ok & ~hwrite;
  assign wr_ctrl   = dp_wr_ff & (dp_addr_ff == OFS_CTRL);
  assign wr_flags  = dp_wr_ff & (dp_addr_ff == OFS_FLAGS);
  assign wr_status = dp_wr_ff & (dp_addr_ff == OFS_STATUS);
  assign wr_addr   = dp_wr_ff & (dp_addr_ff == OFS_ADDR);
  assign wr_data   = dp_wr_ff & (dp_addr_ff == OFS_DATA);
  assign cmd_resp  = wr_ctrl & (hwdata[CTL_CMD+:2] == CMD_RESPOND) & (match_ff | done_ff);
  assign cmd_wait  = wr_ctrl & (hwdata[CTL_CMD+:2] == CMD_WAIT_START);
  assign sm_trig   = sm_pipe_ff[1];
  assign match_clr = (wr_flags & hwdata[FLG_MATCH]) | cmd_resp | cmd_wait;
  assign done_clr  = (wr_flags & hwdata[FLG_DONE]) | wr_data | sm_trig | cmd_resp | cmd_wait;
  assign err_clr   = cmd_resp | (match_ff & match_clr);

  assign rx7 = shift_ff[7:1];
  assign a7  = addr_ff[ADR_LO+:7];
  assign msk = addr_ff[MSK_LO+:7];
  always_comb
  begin
    case (ctrl_ff.scheme)
      AM_MASK:  m7 = ((rx7 ^ a7) & ~msk) == 7'h00;
      AM_TWO:   m7 = (rx7 == a7) | (rx7 == msk);
      AM_RANGE: m7 = (rx7 <= a7) & (rx7 >= msk);
      default:  m7 = 1'b0;
    endcase
  end
  assign gc     = addr_ff[ADR_GC] & (shift_ff == GENERAL_CALL);
  assign ten_hi = (shift_ff[7:3] == TEN_PREFIX) & (shift_ff[2:1] == addr_ff[ADR_LO+8+:2]);
  assign tout_hit = ctrl_ff.tout_en & (tout_ff == TOUT_CYCLES[21:0]);

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_bit       = bit_ff;
    nxt_shift     = shift_ff;
    nxt_scl_oe    = scl_oe;
    nxt_sda_oe    = sda_oe;
    nxt_ten_first = ten_first_ff;
    nxt_ten_hit   = ten_hit_ff;
    ev_match      = 1'b0;
    ev_done       = 1'b0;
    ev_rx         = 1'b0;
    ev_clash      = 1'b0;
    ev_stop       = 1'b0;
    ev_mack       = 1'b0;
    if (scl_rise & (st_ff != ST_IDLE))
    begin
      nxt_bit   = bit_ff + 4'h1;
      nxt_shift = (st_ff == ST_TX) ? shift_ff : {shift_ff[6:0], sda_s};
    end
    case (st_ff)
      ST_ADDR:
      begin
        if (scl_fall & (bit_ff == BITS_BYTE))
        begin
          nxt_bit = 4'h0;
          nxt_st = ST_IDLE;
          if (~addr_ff[ADR_TEN] & (m7 | gc))
          begin
            ev_match   = 1'b1;
            nxt_scl_oe = 1'b1;
            nxt_st     = ST_AHOLD;
          end
          else if (addr_ff[ADR_TEN] & ten_first_ff)
          begin
            nxt_ten_first = 1'b0;
            if (shift_ff == addr_ff[ADR_LO+:8])
            begin
              nxt_ten_hit = 1'b1;
              ev_match    = 1'b1;
              nxt_scl_oe  = 1'b1;
              nxt_st      = ST_AHOLD;
            end
          end
          else if (addr_ff[ADR_TEN] & ten_hi & ~shift_ff[0])
          begin
            // header byte is acked without software
            nxt_ten_first = 1'b1;
            nxt_sda_oe    = 1'b1;
            nxt_st        = ST_ACK;
          end
          else if (addr_ff[ADR_TEN] & ten_hi & ten_hit_ff)
          begin
            ev_match   = 1'b1;
            nxt_scl_oe = 1'b1;
            nxt_st     = ST_AHOLD;
          end
          else if (addr_ff[ADR_TEN] & gc)
          begin
            ev_match   = 1'b1;
            nxt_scl_oe = 1'b1;
            nxt_st     = ST_AHOLD;
          end
        end
      end
      ST_AHOLD:
      begin
        if (match_clr)
        begin
          nxt_scl_oe = 1'b0;
          nxt_sda_oe = ~ctrl_ff.reply_nack & ~cmd_wait;
          nxt_st     = cmd_wait ? ST_IDLE : ST_ACK;
        end
      end
      ST_ACK:
      begin
        if (scl_rise & ~sda_oe & ~sda_s)
          ev_clash = 1'b1;
        else if (scl_fall)
        begin
          nxt_sda_oe = 1'b0;
          nxt_bit    = 4'h0;
          if (~sda_oe)
            nxt_st = ST_IDLE;
          else if (ten_first_ff)
            nxt_st = ST_ADDR;
          else if (dir_ff)
          begin
            ev_done    = 1'b1;
            nxt_scl_oe = 1'b1;
            nxt_st     = ST_DHOLD;
          end
          else
            nxt_st = ST_RX;
        end
      end
      ST_RX:
      begin
        if (scl_fall & (bit_ff == BITS_BYTE))
        begin
          ev_rx      = 1'b1;
          ev_done    = 1'b1;
          nxt_scl_oe = 1'b1;
          nxt_st     = ST_DHOLD;
        end
      end
      ST_DHOLD:
      begin
        if (cmd_wait)
        begin
          nxt_scl_oe = 1'b0;
          nxt_st     = ST_IDLE;
        end
        else if (dir_ff & wr_data)
        begin
          nxt_shift  = hwdata[7:0];
          nxt_sda_oe = ~hwdata[7];
          nxt_bit    = 4'h0;
          nxt_scl_oe = 1'b0;
          nxt_st     = ST_TX;
        end
        else if (~dir_ff & done_ff & done_clr)
        begin
          nxt_sda_oe = ~ctrl_ff.reply_nack;
          nxt_scl_oe = 1'b0;
          nxt_st     = ST_ACK;
        end
      end
      ST_TX:
      begin
        if (scl_rise & ~sda_oe & ~sda_s)
          ev_clash = 1'b1;
        else if (scl_fall & (bit_ff == BITS_BYTE))
        begin
          nxt_sda_oe = 1'b0;
          nxt_st     = ST_MACK;
        end
        else if (scl_fall)
        begin
          nxt_shift  = {shift_ff[6:0], 1'b0};
          nxt_sda_oe = ~shift_ff[6];
        end
      end
      ST_MACK:
      begin
        ev_mack = scl_rise;
        if (scl_fall)
        begin
          nxt_bit = 4'h0;
          if (received_negative_ack_ff)
            nxt_st = ST_IDLE;
          else
          begin
            ev_done    = 1'b1;
            nxt_scl_oe = 1'b1;
            nxt_st     = ST_DHOLD;
          end
        end
      end
      default:
      begin
        nxt_st = ST_IDLE;
      end
    endcase
    if (ev_clash | tout_hit | stop_det | ~ctrl_ff.enable)
    begin
      ev_stop    = stop_det & (st_ff != ST_IDLE);
      nxt_scl_oe = 1'b0;
      nxt_sda_oe = 1'b0;
      nxt_st     = ST_IDLE;
    end
    if (start_det & ctrl_ff.enable)
    begin
      nxt_bit    = 4'h0;
      nxt_scl_oe = 1'b0;
      nxt_sda_oe = 1'b0;
      nxt_st     = ST_ADDR;
    end
  end

  assign ev_berr = bus_act_ff & ((start_det | stop_det) & (frame_ff >= FRAME_MID) | stop_det & fresh_ff);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff        <= ST_IDLE;
      bit_ff       <= 4'h0;
      shift_ff     <= DATA_RST;
      scl_oe       <= 1'b0;
      sda_oe       <= 1'b0;
      ten_first_ff <= 1'b0;
      ten_hit_ff   <= 1'b0;
    end
    else
    begin
      st_ff        <= nxt_st;
      bit_ff       <= nxt_bit;
      shift_ff     <= nxt_shift;
      scl_oe       <= nxt_scl_oe;
      sda_oe       <= nxt_sda_oe;
      ten_first_ff <= nxt_ten_first;
      ten_hit_ff   <= nxt_ten_hit & ~stop_det;
    end
  end

  // bus framing and timeout tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      frame_ff   <= 4'h0;
      bus_act_ff <= 1'b0;
      tout_ff    <= '0;
      rs_ff      <= 1'b0;
      fresh_ff   <= 1'b0;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      if (start_det)
        frame_ff <= 4'h0;
      else if (scl_rise)
        frame_ff <= (frame_ff == BITS_FRAME) ? FRAME_ONE : frame_ff + 4'h1;
      // start while busy counts as repeated start
      if (start_det)
      begin
        bus_act_ff <= 1'b1;
        rs_ff      <= bus_act_ff;
      end
      else if (stop_det | tout_hit)
        bus_act_ff <= 1'b0;
      // start, at most one clock rise, then stop
      if (start_det)
        fresh_ff <= 1'b1;
      else if (scl_rise & (frame_ff != 4'h0))
        fresh_ff <= 1'b0;
      // count only while a frame holds scl low
      if (scl_s | ~bus_act_ff | tout_hit)
        tout_ff <= '0;
      else
        tout_ff <= tout_ff + 22'h1;
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= '0;
      addr_ff <= ADDR_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_ff.enable     <= hwdata[CTL_EN];
        ctrl_ff.smart      <= hwdata[CTL_SM];
        ctrl_ff.reply_nack <= hwdata[CTL_NACK];
        ctrl_ff.scheme     <= hwdata[CTL_AM+:2];
        ctrl_ff.tout_en    <= hwdata[CTL_TO];
      end
      if (wr_addr & ~ctrl_ff.enable)
        addr_ff <= hwdata & ADDR_WMASK;
    end
  end

  // event flags and status; a set beats a clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      match_ff  <= 1'b0;
      done_ff   <= 1'b0;
      stop_ff   <= 1'b0;
      berr_ff   <= 1'b0;
      clash_ff  <= 1'b0;
      received_negative_ack_ff <= 1'b0;
      dir_ff    <= 1'b0;
      sr_ff     <= 1'b0;
    end
    else
    begin
      match_ff <= ev_match | (match_ff & ~match_clr);
      done_ff  <= ev_done | (done_ff & ~done_clr);
      stop_ff  <= ev_stop | (stop_ff & ~(wr_flags & hwdata[FLG_STOP]));
      berr_ff  <= ev_berr | tout_hit | (berr_ff & ~err_clr & ~(wr_status & hwdata[STA_BERR]));
      // clash set and clear, no interrupt
      clash_ff <= ev_clash | (clash_ff & ~err_clr & ~(wr_status & hwdata[STA_CLSH]));
      if (ev_mack)
        received_negative_ack_ff <= sda_s;
      if (ev_match)
      begin
        dir_ff <= shift_ff[0];
        sr_ff  <= rs_ff;
      end
    end
  end

  // data buffer and ahb slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_ff    <= DATA_RST;
      dp_wr_ff   <= 1'b0;
      dp_addr_ff <= 8'h00;
      sm_pipe_ff <= 2'b00;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end
    else
    begin
      dp_wr_ff   <= ap_ok & hwrite;
      dp_addr_ff <= haddr[7:0];
      // smart reads take two cycles to act
      sm_pipe_ff <= {sm_pipe_ff[0], rd_now & (haddr[7:0] == OFS_DATA) & ctrl_ff.smart};
      // software must only touch this while held
      if (ev_rx)
        data_ff <= shift_ff;
      else if (wr_data)
        data_ff <= hwdata[7:0];
      if (rd_now)
      begin
        case (haddr[7:0])
          OFS_CTRL:   hrdata <= {24'h00_0000, ctrl_ff.tout_en, 2'b00, ctrl_ff.scheme,
                                 ctrl_ff.reply_nack, ctrl_ff.smart, ctrl_ff.enable};
          OFS_FLAGS:  hrdata <= {29'h0000_0000, done_ff, match_ff, stop_ff};
          // stretching bit is the held clock
          OFS_STATUS: hrdata <= {24'h00_0000, scl_oe, 2'b00, sr_ff, dir_ff, received_negative_ack_ff, clash_ff, berr_ff};
          OFS_ADDR:   hrdata <= addr_ff;
          OFS_DATA:   hrdata <= {24'h00_0000, data_ff};
          default:    hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/iss_sync.sv
`timescale 1ns/1ps
`default_nettype none
module iss_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // async in, synced out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // idle level of the pulled-up lines, so no false edge after reset
      meta_ff <= '1;
      dout    <= '1;
    end
    else
    begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule
`default_nettype wire
